// >>> rtl/tpgi_gate_input.sv
// Top of the three-phase gate input logic: permits, resets, legs and level flags
`timescale 1ns/1ps
`default_nettype none
module tpgi_gate_input #(
	parameter int LEVEL_W = tpgi_pkg::LEVEL_W_DEF,
	parameter int DEAD_CYC = tpgi_pkg::DEAD_TIME_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic drivePermitFirst,
	input wire logic drivePermitSecond,
	input wire logic deviceResetN,
	input wire logic logicSupplyGood,
	input wire logic crossConductOverride,
	input wire logic deadTimeOverride,
	input wire logic legAUpperRequestN,
	input wire logic legALowerRequest,
	input wire logic legBUpperRequestN,
	input wire logic legBLowerRequest,
	input wire logic legCUpperRequestN,
	input wire logic legCLowerRequest,
	input wire logic [LEVEL_W-1:0] loadSupply,
	input wire logic [LEVEL_W-1:0] legASourceLevel,
	input wire logic [LEVEL_W-1:0] legBSourceLevel,
	input wire logic [LEVEL_W-1:0] legCSourceLevel,
	output logic legAUpperGate,
	output logic legAUpperGateOe,
	output logic legALowerGate,
	output logic legALowerGateOe,
	output logic legBUpperGate,
	output logic legBUpperGateOe,
	output logic legBLowerGate,
	output logic legBLowerGateOe,
	output logic legCUpperGate,
	output logic legCUpperGateOe,
	output logic legCLowerGate,
	output logic legCLowerGateOe,
	output logic legAHalfSupplyFlag,
	output logic legBHalfSupplyFlag,
	output logic legCHalfSupplyFlag,
	output logic logicRegulatorEnable,
	output logic biasEnable,
	output logic serialPortEnable,
	output logic lowPowerState
);
	import tpgi_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [LEG_COUNT-1:0] primed;
		logic [LEG_COUNT-1:0] flag;
	} tpgi_top_regs_t;

	tpgi_top_regs_t regsReg;
	tpgi_top_regs_t regsNext;

	logic permit;
	logic logicActive;
	logic legClear;
	logic [LEG_COUNT-1:0] upperReqN;
	logic [LEG_COUNT-1:0] lowerReq;
	logic [LEG_COUNT-1:0] upperWant;
	logic [LEG_COUNT-1:0] lowerWant;
	logic [LEG_COUNT-1:0] rawConflict;
	logic [LEG_COUNT-1:0] shootBlock;
	logic [LEG_COUNT-1:0] upperOn;
	logic [LEG_COUNT-1:0] lowerOn;
	logic [LEG_COUNT-1:0] upperGate;
	logic [LEG_COUNT-1:0] lowerGate;
	logic [LEVEL_W:0] sourceTwice [LEG_COUNT];

	// ----------------------------------------------------------------
	// Permits and resets
	// ----------------------------------------------------------------
	// Permit path is purely combinational so it acts without a clock edge
	assign permit = drivePermitFirst & drivePermitSecond;
	assign logicActive = deviceResetN & logicSupplyGood;
	// Logic is cleared on the first edge after the reset pin falls
	assign legClear = ~logicActive | ~permit;

	assign logicRegulatorEnable = deviceResetN;
	assign biasEnable = deviceResetN;
	assign lowPowerState = ~deviceResetN;
	// Serial access runs with permits low but not in reset or before power is good
	assign serialPortEnable = logicActive;

	// ----------------------------------------------------------------
	// Request pins
	// ----------------------------------------------------------------
	assign upperReqN = {legCUpperRequestN, legBUpperRequestN, legAUpperRequestN};
	assign lowerReq = {legCLowerRequest, legBLowerRequest, legALowerRequest};
	assign sourceTwice[0] = {legASourceLevel, 1'b0};
	assign sourceTwice[1] = {legBSourceLevel, 1'b0};
	assign sourceTwice[2] = {legCSourceLevel, 1'b0};

	// ----------------------------------------------------------------
	// Per-leg guards and gate pins
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LEG_COUNT; g++)
		begin : gLeg
			// Conflict is judged on the raw pins, so an unprimed upper request still
			// withdraws the lower switch instead of letting it stay on
			assign rawConflict[g] = ~upperReqN[g] & lowerReq[g] & ~crossConductOverride;
			// Upper switch held off until its bootstrap leg has been pulsed low
			assign upperWant[g] = ~upperReqN[g] & regsReg.primed[g] & ~rawConflict[g];
			assign lowerWant[g] = lowerReq[g] & ~rawConflict[g];

			tpgi_leg_guard #(
				.DEAD_CYC(DEAD_CYC)
			) uGuard (
				.sys_clk(sys_clk),
				.rst(rst),
				.clear(legClear),
				.upperWant(upperWant[g]),
				.lowerWant(lowerWant[g]),
				.crossOverride(crossConductOverride),
				.deadOverride(deadTimeOverride),
				.upperOn(upperOn[g]),
				.lowerOn(lowerOn[g])
			);

			// Dropping the override while both are on must not leave a cycle of overlap
			assign shootBlock[g] = upperOn[g] & lowerOn[g] & ~crossConductOverride;
			assign upperGate[g] = upperOn[g] & ~shootBlock[g] & permit & logicActive;
			assign lowerGate[g] = lowerOn[g] & ~shootBlock[g] & permit & logicActive;
		end
	endgenerate

	assign legAUpperGate = upperGate[0];
	assign legALowerGate = lowerGate[0];
	assign legBUpperGate = upperGate[1];
	assign legBLowerGate = lowerGate[1];
	assign legCUpperGate = upperGate[2];
	assign legCLowerGate = lowerGate[2];

	// Gates are actively pulled low with permits off, released in reset or power-up
	assign legAUpperGateOe = logicActive;
	assign legALowerGateOe = logicActive;
	assign legBUpperGateOe = logicActive;
	assign legBLowerGateOe = logicActive;
	assign legCUpperGateOe = logicActive;
	assign legCLowerGateOe = logicActive;

	// ----------------------------------------------------------------
	// Bootstrap priming and half-supply flags
	// ----------------------------------------------------------------
	always_comb
	begin
		regsNext = regsReg;
		for (int i = 0; i < LEG_COUNT; i++)
		begin
			if (!permit || !logicActive)
			begin
				regsNext.primed[i] = 1'b0;
			end
			else if (lowerOn[i])
			begin
				regsNext.primed[i] = 1'b1;
			end
			if (!logicActive)
			begin
				regsNext.flag[i] = 1'b0;
			end
			else
			begin
				regsNext.flag[i] = sourceTwice[i] >= {1'b0, loadSupply};
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			regsReg <= '{primed: PRIMED_RESET, flag: FLAG_RESET};
		end
		else
		begin
			regsReg <= regsNext;
		end
	end

	assign legAHalfSupplyFlag = regsReg.flag[0];
	assign legBHalfSupplyFlag = regsReg.flag[1];
	assign legCHalfSupplyFlag = regsReg.flag[2];

endmodule
`default_nettype wire

// >>> rtl/tpgi_leg_guard.sv
// One leg: cross-conduction interlock and dead-time blanking
`timescale 1ns/1ps
`default_nettype none
module tpgi_leg_guard #(
	parameter int DEAD_CYC = tpgi_pkg::DEAD_TIME_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic upperWant,
	input wire logic lowerWant,
	input wire logic crossOverride,
	input wire logic deadOverride,
	output logic upperOn,
	output logic lowerOn
);
	import tpgi_pkg::*;

	localparam int CNT_W = $clog2(DEAD_CYC + 1);
	localparam logic [CNT_W-1:0] BLANK_LOAD = CNT_W'(DEAD_CYC - 1);

	typedef struct packed {
		tpgi_leg_state_t state;
		logic [CNT_W-1:0] blank;
	} tpgi_leg_regs_t;

	tpgi_leg_regs_t regsReg;
	tpgi_leg_regs_t regsNext;
	logic conflict;
	tpgi_leg_state_t offState;

	always_comb
	begin
		regsNext = regsReg;
		conflict = upperWant & lowerWant & ~crossOverride;
		offState = deadOverride ? LEG_IDLE : LEG_BLANK;
		case (regsReg.state)
			LEG_IDLE:
			begin
				if (conflict)
				begin
					regsNext.state = LEG_IDLE;
				end
				else if (upperWant & lowerWant)
				begin
					regsNext.state = LEG_BOTH;
				end
				else if (upperWant)
				begin
					regsNext.state = LEG_UPPER;
				end
				else if (lowerWant)
				begin
					regsNext.state = LEG_LOWER;
				end
			end
			LEG_UPPER:
			begin
				if (!upperWant || conflict)
				begin
					regsNext.state = offState;
				end
				else if (lowerWant)
				begin
					regsNext.state = LEG_BOTH;
				end
			end
			LEG_LOWER:
			begin
				if (!lowerWant || conflict)
				begin
					regsNext.state = offState;
				end
				else if (upperWant)
				begin
					regsNext.state = LEG_BOTH;
				end
			end
			LEG_BOTH:
			begin
				if (!(upperWant & lowerWant) || !crossOverride)
				begin
					regsNext.state = offState;
				end
			end
			LEG_BLANK:
			begin
				if (deadOverride || regsReg.blank == '0)
				begin
					regsNext.state = LEG_IDLE;
				end
				else
				begin
					regsNext.blank = regsReg.blank - 1'b1;
				end
			end
			default:
			begin
				regsNext.state = LEG_IDLE;
			end
		endcase
		if (regsNext.state == LEG_BLANK && regsReg.state != LEG_BLANK)
		begin
			regsNext.blank = BLANK_LOAD;
		end
		if (clear)
		begin
			regsNext.state = LEG_IDLE;
			regsNext.blank = '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			regsReg <= '{state: LEG_IDLE, blank: '0};
		end
		else
		begin
			regsReg <= regsNext;
		end
	end

	assign upperOn = (regsReg.state == LEG_UPPER) || (regsReg.state == LEG_BOTH);
	assign lowerOn = (regsReg.state == LEG_LOWER) || (regsReg.state == LEG_BOTH);

endmodule
`default_nettype wire

// >>> rtl/tpgi_pkg.sv
// Constants shared by the three-phase gate input logic
package tpgi_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 10000;
	localparam int RESET_LATENCY_NS = 77;
	localparam int RESET_LATENCY_CYC = (RESET_LATENCY_NS * 1000) / CLK_PERIOD_PS;
	localparam int DEAD_TIME_NS = 500;
	localparam int DEAD_TIME_CYC = ((DEAD_TIME_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int LEG_COUNT = 3;
	localparam int LEVEL_W_DEF = 10;
	localparam logic [2:0] PRIMED_RESET = 3'h0;
	localparam logic [2:0] FLAG_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Leg guard states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LEG_IDLE = 3'b000,
		LEG_UPPER = 3'b001,
		LEG_LOWER = 3'b010,
		LEG_BOTH = 3'b011,
		LEG_BLANK = 3'b100
	} tpgi_leg_state_t;

endpackage

// >>> tb/tb_tpgi_gate_input.sv
// Self-checking bench for the three-phase gate input logic
`timescale 1ns/1ps
`default_nettype none
module tb_tpgi_gate_input;
	import tpgi_pkg::*;
	localparam int DC = 3;
	localparam int LW = 10;
	logic sys_clk = 1'b0, rst = 1'b1, skipPrime = 1'b0, floatPins = 1'b0;
	logic drivePermitFirst = 1'b1, drivePermitSecond = 1'b1, deviceResetN = 1'b1;
	logic logicSupplyGood = 1'b1, crossConductOverride = 1'b0, deadTimeOverride = 1'b0;
	logic [2:0] upWant = 3'h0, loWant = 3'h0;
	logic [LW-1:0] loadSupply = 10'h100, legASourceLevel = 10'h200;
	logic [LW-1:0] legBSourceLevel = 10'h200, legCSourceLevel = 10'h200;
	wire logic legAUpperRequestN, legALowerRequest, legBUpperRequestN, legBLowerRequest;
	wire logic legCUpperRequestN, legCLowerRequest, legAUpperGate, legALowerGate;
	wire logic legBUpperGate, legBLowerGate, legCUpperGate, legCLowerGate, legAUpperGateOe;
	wire logic legALowerGateOe, legBUpperGateOe, legBLowerGateOe, legCUpperGateOe;
	wire logic legCLowerGateOe, legAHalfSupplyFlag, legBHalfSupplyFlag, legCHalfSupplyFlag;
	wire logic logicRegulatorEnable, biasEnable, serialPortEnable, lowPowerState;
	wire logic permitOk = drivePermitFirst & drivePermitSecond & deviceResetN & logicSupplyGood;
	wire logic [7:0] gates = {2'h0, legCUpperGate, legBUpperGate, legAUpperGate,
		legCLowerGate, legBLowerGate, legALowerGate};
	wire logic [7:0] flags = {5'h0, legCHalfSupplyFlag, legBHalfSupplyFlag, legAHalfSupplyFlag};
	wire logic [5:0] oes = {legCLowerGateOe, legCUpperGateOe, legBLowerGateOe,
		legBUpperGateOe, legALowerGateOe, legAUpperGateOe};
	int error_cnt = 0, cmp_count = 0, cycles = 0, seed = 32'h8a7a;
	tpgi_host_model i_tpgi_host_model (.*);
	tpgi_gate_input #(.LEVEL_W(LW), .DEAD_CYC(DC)) i_tpgi_gate_input (.*);
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
		$display("test %s done", what);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	function automatic logic [7:0] expFlag(input logic [LW-1:0] l, a, b, c);
		return {5'h0, {c, 1'b0} >= {1'b0, l}, {b, 1'b0} >= {1'b0, l}, {a, 1'b0} >= {1'b0, l}};
	endfunction
	task report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial
	begin
		cyc(3);
		rst <= 1'b0;
		loWant <= 3'h7;
		cyc(2);
		#1 chk("lower gates", 8'h07, gates);
		cyc(1);
		loWant <= 3'h0;
		upWant <= 3'h7;
		cyc(DC + 10);
		#1 chk("upper after priming", 8'h38, gates);
		cyc(1);
		drivePermitFirst <= 1'b0;
		#1 chk("permit one low", 8'h00, gates);
		cyc(1);
		drivePermitFirst <= 1'b1;
		skipPrime <= 1'b1;
		cyc(DC + 10);
		#1 chk("upper without priming", 8'h00, gates);
		cyc(1);
		skipPrime <= 1'b0;
		cyc(DC + 1);
		#1 chk("dead time blanking", 8'h00, gates);
		cyc(9);
		#1 chk("upper primed again", 8'h38, gates);
		cyc(1);
		drivePermitSecond <= 1'b0;
		#1 chk("permit two low", 8'h00, gates);
		cyc(1);
		drivePermitSecond <= 1'b1;
		loWant <= 3'h7;
		cyc(DC + 10);
		#1 chk("both requested", 8'h00, gates);
		cyc(1);
		crossConductOverride <= 1'b1;
		deadTimeOverride <= 1'b1;
		cyc(6);
		#1 chk("both with overrides", 8'h3f, gates);
		cyc(1);
		crossConductOverride <= 1'b0;
		deadTimeOverride <= 1'b0;
		floatPins <= 1'b1;
		cyc(DC + 10);
		#1 chk("floating requests", 8'h00, gates);
		chk("flags before reset", 8'h07, flags);
		cyc(1);
		deviceResetN <= 1'b0;
		#1 chk("reset pin outputs", 8'h02, {oes, lowPowerState,
			logicRegulatorEnable | biasEnable | serialPortEnable});
		cyc(7);
		#1 chk("flags after reset", 8'h00, flags);
		cyc(1);
		deviceResetN <= 1'b1;
		logicSupplyGood <= 1'b0;
		#1 chk("supply low outputs", 8'h00, {1'b0, serialPortEnable, oes});
		cyc(1);
		logicSupplyGood <= 1'b1;
		for (int i = 0; i < 30; i++)
		begin
			cyc(1);
			loadSupply <= (i == 0) ? 10'h200 : 10'($random(seed));
			legASourceLevel <= (i == 0) ? 10'h100 : 10'($random(seed));
			legBSourceLevel <= (i == 0) ? 10'h0ff : 10'($random(seed));
			legCSourceLevel <= (i == 0) ? 10'h3ff : 10'($random(seed));
			cyc(1);
			#1 chk("half supply flags", expFlag(loadSupply, legASourceLevel,
				legBSourceLevel, legCSourceLevel), flags);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> tb/tpgi_gate_input_asserts.sv
// Concurrent checks on the gate input logic ports
`timescale 1ns/1ps
`default_nettype none
module tpgi_gate_input_asserts #(
	parameter int LEVEL_W = 10
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic drivePermitFirst,
	input wire logic drivePermitSecond,
	input wire logic deviceResetN,
	input wire logic logicSupplyGood,
	input wire logic crossConductOverride,
	input wire logic legAUpperRequestN,
	input wire logic legALowerRequest,
	input wire logic [LEVEL_W-1:0] loadSupply,
	input wire logic [LEVEL_W-1:0] legASourceLevel,
	input wire logic legAUpperGate,
	input wire logic legALowerGate,
	input wire logic legAUpperGateOe,
	input wire logic legAHalfSupplyFlag,
	input wire logic logicRegulatorEnable,
	input wire logic biasEnable,
	input wire logic serialPortEnable,
	input wire logic lowPowerState
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_permit_gate: assert property (!(drivePermitFirst && drivePermitSecond)
		|-> !legAUpperGate && !legALowerGate) else $error("gate on without permit");
	chk_reset_lowpower: assert property (!deviceResetN |-> lowPowerState && !biasEnable
		&& !logicRegulatorEnable && !legAUpperGateOe) else $error("reset pin not low power");
	chk_por_float: assert property (!logicSupplyGood
		|-> !serialPortEnable && !legAUpperGateOe) else $error("driven before supply good");
	chk_no_shoot: assert property (!crossConductOverride
		|-> !(legAUpperGate && legALowerGate)) else $error("both switches on");
	chk_both_off: assert property (!crossConductOverride && !legAUpperRequestN
		&& legALowerRequest |=> !legAUpperGate && !legALowerGate) else $error("conflict not off");
	chk_reset_clear: assert property ($fell(deviceResetN)
		|-> ##[0:7] !legAHalfSupplyFlag) else $error("flag not cleared by reset pin");
	chk_flag_level: assert property (deviceResetN && logicSupplyGood |=> legAHalfSupplyFlag
		== $past({legASourceLevel, 1'b0} >= {1'b0, loadSupply})) else $error("flag level wrong");
	chk_upper_pol: assert property ($rose(legAUpperGate)
		|-> $past(!legAUpperRequestN)) else $error("upper on without request");
	cover property (legAUpperGate);
	cover property (legAUpperGate && legALowerGate);
	cover property ($fell(deviceResetN));
endmodule
bind tpgi_gate_input tpgi_gate_input_asserts #(.LEVEL_W(LEVEL_W)) i_tpgi_gate_input_asserts (.*);
`default_nettype wire

// >>> tb/tpgi_host_model.sv
// Host model driving the six leg request pins
`timescale 1ns/1ps
`default_nettype none
module tpgi_host_model (
	input wire logic sys_clk,
	input wire logic permitOk,
	input wire logic skipPrime,
	input wire logic floatPins,
	input wire logic [2:0] upWant,
	input wire logic [2:0] loWant,
	output logic legAUpperRequestN,
	output logic legALowerRequest,
	output logic legBUpperRequestN,
	output logic legBLowerRequest,
	output logic legCUpperRequestN,
	output logic legCLowerRequest
);
	logic [2:0] primeDue = 3'h7;
	logic [2:0] pulse;
	always @(posedge sys_clk)
		primeDue <= permitOk ? (primeDue & ~pulse) : 3'h7;
	assign pulse = primeDue & upWant & {3{!skipPrime}};
	// Released pins read as pulled: upper high, lower low
	assign {legCUpperRequestN, legBUpperRequestN, legAUpperRequestN} =
		floatPins ? 3'h7 : ~(upWant & ~pulse);
	assign {legCLowerRequest, legBLowerRequest, legALowerRequest} =
		floatPins ? 3'h0 : (loWant | pulse);
endmodule
`default_nettype wire
